/* src/tcs_map.svh */
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH

// Status word field positions, reset values, user mode code and register counts
`define TCS_PSW_CUR_HI      15
`define TCS_PSW_CUR_LO      14
`define TCS_PSW_PRV_HI      13
`define TCS_PSW_PRV_LO      12
`define TCS_PSW_RSET        11
`define TCS_PSW_RESET_VAL   16'h0000
`define TCS_PC_RESET_VAL    16'h0000
`define TCS_SP_RESET_VAL    16'h0000
`define TCS_MODE_USER       2'h3
`define TCS_NUM_GPR         6
`define TCS_NUM_SP          4

// Vector addresses per cause
`define TCS_VEC_ODD_ADDR    16'h0004
`define TCS_VEC_RESERVED    16'h0010
`define TCS_VEC_IO_TRAP     16'h0014
`define TCS_VEC_EMU_TRAP    16'h0018
`define TCS_VEC_TRAP        16'h001C

`endif

/* src/tcs_pkg.sv */
package tcs_pkg;

   typedef enum logic [2:0] {
      TCS_CAUSE_NONE     = 3'h0,
      TCS_CAUSE_ODD_ADDR = 3'h1,
      TCS_CAUSE_RESERVED = 3'h2,
      TCS_CAUSE_EMU_TRAP = 3'h3,
      TCS_CAUSE_TRAP     = 3'h4,
      TCS_CAUSE_IO_TRAP  = 3'h5,
      TCS_CAUSE_INTR     = 3'h6
   } tcs_cause_t;

   typedef enum logic [2:0] {
      TCS_OP_NONE    = 3'h0,
      TCS_OP_MOVE_TO_PREV_ISPACE   = 3'h1,
      TCS_OP_MOVE_TO_PREV_DSPACE   = 3'h2,
      TCS_OP_MOVE_FROM_PREV_ISPACE = 3'h3,
      TCS_OP_MOVE_FROM_PREV_DSPACE = 3'h4,
      TCS_OP_RET_INT = 3'h5,
      TCS_OP_RET_TRP = 3'h6
   } tcs_op_t;

   // Gray codes in declaration order; one bit per step along the trap push/load path up to TCS_ST_VEC_S
   typedef enum logic [3:0] {
      TCS_ST_IDLE   = 4'h0,
      TCS_ST_PUSH_S = 4'h1,
      TCS_ST_PUSH_P = 4'h3,
      TCS_ST_VEC_P  = 4'h2,
      TCS_ST_VEC_S  = 4'h6,
      TCS_ST_POP_P  = 4'h7,
      TCS_ST_POP_S  = 4'h5,
      TCS_ST_XFER   = 4'h4,
      TCS_ST_PUSH_X = 4'hC
   } tcs_state_t;

   typedef struct packed {
      logic        req;
      logic        wr;
      logic        ispace;
      logic [1:0]  mode;
      logic [15:0] addr;
      logic [15:0] wdata;
   } tcs_mem_req_t;

   typedef struct packed {
      logic        ack;
      logic [15:0] rdata;
   } tcs_mem_rsp_t;

endpackage : tcs_pkg

/* src/tcs_gpr_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcs_map.svh"

// Two sets of general registers 0..5, registered read
module tcs_gpr_bank (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        set_sel,
   input  wire logic        we,
   input  wire logic [2:0]  waddr,
   input  wire logic [15:0] wdata,
   input  wire logic [2:0]  raddr,
   output var  logic [15:0] rdata
);

   logic [15:0] mem_q [0:2*`TCS_NUM_GPR-1];
   wire  [3:0]  widx = {set_sel, waddr};
   wire  [3:0]  ridx = {set_sel, raddr};
   wire         wok  = we && (waddr < 3'h6);
   wire         rok  = raddr < 3'h6;

   genvar g;
   generate
      for (g = 0; g < 2*`TCS_NUM_GPR; g++) begin : g_reg
         localparam logic [3:0] IDX = 4'((g / `TCS_NUM_GPR) * 8 + (g % `TCS_NUM_GPR));
         always_ff @(posedge clk) begin
            if (!rst_n)
               mem_q[g] <= 16'h0000;
            else if (wok && widx == IDX)
               mem_q[g] <= wdata;
         end
      end
   endgenerate

   wire [3:0] rpos = 4'({3'h0, ridx[3]} * 4'h6) + {1'b0, ridx[2:0]};

   always_ff @(posedge clk) begin
      if (!rst_n)
         rdata <= 16'h0000;
      else
         rdata <= rok ? mem_q[rpos] : 16'h0000;
   end

endmodule : tcs_gpr_bank
`default_nettype wire

/* src/tcs_sp_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcs_map.svh"

// One stack pointer per mode
module tcs_sp_bank (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  sel,
   input  wire logic        we,
   input  wire logic [15:0] wdata,
   output var  logic [15:0] rdata
);

   logic [15:0] sp_q [0:`TCS_NUM_SP-1];

   genvar g;
   generate
      for (g = 0; g < `TCS_NUM_SP; g++) begin : g_sp
         always_ff @(posedge clk) begin
            if (!rst_n)
               sp_q[g] <= `TCS_SP_RESET_VAL;
            else if (we && sel == 2'(g))
               sp_q[g] <= wdata;
         end
      end
   endgenerate

   assign rdata = sp_q[sel];

endmodule : tcs_sp_bank
`default_nettype wire

/* src/tcs_trap_context_switch.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcs_map.svh"

module tcs_trap_context_switch (
   input  wire logic                  REF_CLK,
   input  wire logic                  RST_N,
   input  wire tcs_pkg::tcs_cause_t   TRAP_CAUSE,
   input  wire logic [15:0]           INTR_VECTOR,
   input  wire tcs_pkg::tcs_op_t      OP,
   input  wire logic [15:0]           OP_ADDR,
   input  wire logic                  OP_WORD,
   input  wire logic                  OP_START,
   input  wire logic [15:0]           CUR_PC,
   input  wire logic                  CONST_FETCH,
   input  wire logic [15:0]           CONST_ADDR,
   input  wire logic                  GPR_WE,
   input  wire logic [2:0]            GPR_WADDR,
   input  wire logic [15:0]           GPR_WDATA,
   input  wire logic [2:0]            GPR_RADDR,
   input  wire tcs_pkg::tcs_mem_rsp_t MEM_RSP,
   output tcs_pkg::tcs_mem_req_t      MEM_REQ,
   output logic [15:0]                GPR_RDATA,
   output logic [15:0]                PC_OUT,
   output logic [15:0]                PSW_OUT,
   output logic [15:0]                SP_OUT,
   output logic [15:0]                XFER_DATA,
   output logic                       BUSY,
   output logic                       DONE,
   output logic                       PC_LOAD
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   tcs_pkg::tcs_state_t state_q, state_d;
   logic [15:0] psw_q, psw_d;
   logic [15:0] pc_q, pc_d;
   // Interrupted PC kept apart so PC_OUT only moves on a load
   logic [15:0] spc_q, spc_d;
   logic [15:0] vec_q, vec_d;
   logic [15:0] tmp_q, tmp_d;
   logic [15:0] xaddr_q, xaddr_d;
   tcs_pkg::tcs_op_t op_q, op_d;
   logic done_q, done_d;
   logic pcl_q, pcl_d;

   wire [1:0]  cur_mode = psw_q[`TCS_PSW_CUR_HI:`TCS_PSW_CUR_LO];
   wire [1:0]  prv_mode = psw_q[`TCS_PSW_PRV_HI:`TCS_PSW_PRV_LO];
   wire        rset     = psw_q[`TCS_PSW_RSET];
   wire [15:0] sp;
   logic        sp_we;
   logic [15:0] sp_wdata;

   ////////////////////////////////////////////////////////////////////////////
   // Register banks
   tcs_gpr_bank u_gpr (
      .clk     (REF_CLK),
      .rst_n   (RST_N),
      .set_sel (rset),
      .we      (GPR_WE),
      .waddr   (GPR_WADDR),
      .wdata   (GPR_WDATA),
      .raddr   (GPR_RADDR),
      .rdata   (GPR_RDATA)
   );

   tcs_sp_bank u_sp (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .sel   (cur_mode),
      .we    (sp_we),
      .wdata (sp_wdata),
      .rdata (sp)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Trap cause decode
   // One decode wire per cross-space move
   wire op_to_i   = OP == tcs_pkg::TCS_OP_MOVE_TO_PREV_ISPACE;
   wire op_to_d   = OP == tcs_pkg::TCS_OP_MOVE_TO_PREV_DSPACE;
   wire op_from_i = OP == tcs_pkg::TCS_OP_MOVE_FROM_PREV_ISPACE;
   wire op_from_d = OP == tcs_pkg::TCS_OP_MOVE_FROM_PREV_DSPACE;
   wire is_xfer   = op_to_i || op_to_d || op_from_i || op_from_d;
   // Odd word move never reaches memory
   wire odd_word  = OP_START && OP_WORD && OP_ADDR[0] && is_xfer;
   wire trap_in  = (TRAP_CAUSE != tcs_pkg::TCS_CAUSE_NONE) || odd_word;
   wire [15:0] vec_sel =
      odd_word                                    ? `TCS_VEC_ODD_ADDR :
      TRAP_CAUSE == tcs_pkg::TCS_CAUSE_ODD_ADDR   ? `TCS_VEC_ODD_ADDR :
      TRAP_CAUSE == tcs_pkg::TCS_CAUSE_RESERVED   ? `TCS_VEC_RESERVED :
      TRAP_CAUSE == tcs_pkg::TCS_CAUSE_EMU_TRAP   ? `TCS_VEC_EMU_TRAP :
      TRAP_CAUSE == tcs_pkg::TCS_CAUSE_TRAP       ? `TCS_VEC_TRAP     :
      TRAP_CAUSE == tcs_pkg::TCS_CAUSE_IO_TRAP    ? `TCS_VEC_IO_TRAP  :
                                                    INTR_VECTOR;

   wire is_ret  = OP == tcs_pkg::TCS_OP_RET_INT || OP == tcs_pkg::TCS_OP_RET_TRP;
   // Direction and space of the move in flight
   wire op_to   = op_q == tcs_pkg::TCS_OP_MOVE_TO_PREV_ISPACE ||
                  op_q == tcs_pkg::TCS_OP_MOVE_TO_PREV_DSPACE;
   wire op_isp  = op_q == tcs_pkg::TCS_OP_MOVE_TO_PREV_ISPACE ||
                  op_q == tcs_pkg::TCS_OP_MOVE_FROM_PREV_ISPACE;
   wire ack     = MEM_RSP.ack;
   wire idle    = state_q == tcs_pkg::TCS_ST_IDLE;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      state_d  = state_q;
      psw_d    = psw_q;
      pc_d     = pc_q;
      spc_d    = spc_q;
      vec_d    = vec_q;
      tmp_d    = tmp_q;
      xaddr_d  = xaddr_q;
      op_d     = op_q;
      done_d   = 1'b0;
      pcl_d    = 1'b0;
      sp_we    = 1'b0;
      sp_wdata = sp;
      MEM_REQ  = '0;
      MEM_REQ.mode = cur_mode;
      unique case (state_q)
         tcs_pkg::TCS_ST_IDLE: begin
            if (trap_in) begin
               vec_d   = vec_sel;
               spc_d   = CUR_PC;
               state_d = tcs_pkg::TCS_ST_PUSH_S;
            end else if (OP_START && is_xfer) begin
               op_d    = OP;
               xaddr_d = OP_ADDR;
               state_d = tcs_pkg::TCS_ST_XFER;
            end else if (OP_START && is_ret) begin
               op_d    = OP;
               state_d = tcs_pkg::TCS_ST_POP_P;
            end
            if (CONST_FETCH) begin
               MEM_REQ.req    = 1'b1;
               MEM_REQ.ispace = 1'b1;
               MEM_REQ.addr   = CONST_ADDR;
            end
         end
         // Trap: status word goes on the stack before the PC
         tcs_pkg::TCS_ST_PUSH_S: begin
            MEM_REQ.req   = 1'b1;
            MEM_REQ.wr    = 1'b1;
            MEM_REQ.addr  = sp - 16'h0002;
            MEM_REQ.wdata = psw_q;
            if (ack) begin
               sp_we    = 1'b1;
               sp_wdata = sp - 16'h0002;
               state_d  = tcs_pkg::TCS_ST_PUSH_P;
            end
         end
         tcs_pkg::TCS_ST_PUSH_P: begin
            MEM_REQ.req   = 1'b1;
            MEM_REQ.wr    = 1'b1;
            MEM_REQ.addr  = sp - 16'h0002;
            MEM_REQ.wdata = spc_q;
            if (ack) begin
               sp_we    = 1'b1;
               sp_wdata = sp - 16'h0002;
               state_d  = tcs_pkg::TCS_ST_VEC_P;
            end
         end
         // Vector: PC word first, status word next, always in mode 0
         tcs_pkg::TCS_ST_VEC_P: begin
            MEM_REQ.req  = 1'b1;
            MEM_REQ.mode = 2'h0;
            MEM_REQ.addr = vec_q;
            if (ack) begin
               tmp_d   = MEM_RSP.rdata;
               state_d = tcs_pkg::TCS_ST_VEC_S;
            end
         end
         tcs_pkg::TCS_ST_VEC_S: begin
            MEM_REQ.req  = 1'b1;
            MEM_REQ.mode = 2'h0;
            MEM_REQ.addr = vec_q + 16'h0002;
            if (ack) begin
               pc_d    = tmp_q;
               // New status keeps old current mode as previous
               psw_d   = {MEM_RSP.rdata[15:14], cur_mode, MEM_RSP.rdata[11:0]};
               pcl_d   = 1'b1;
               done_d  = 1'b1;
               state_d = tcs_pkg::TCS_ST_IDLE;
            end
         end
         // Return: PC popped first, status word last
         tcs_pkg::TCS_ST_POP_P: begin
            MEM_REQ.req  = 1'b1;
            MEM_REQ.addr = sp;
            if (ack) begin
               tmp_d    = MEM_RSP.rdata;
               sp_we    = 1'b1;
               sp_wdata = sp + 16'h0002;
               state_d  = tcs_pkg::TCS_ST_POP_S;
            end
         end
         tcs_pkg::TCS_ST_POP_S: begin
            MEM_REQ.req  = 1'b1;
            MEM_REQ.addr = sp;
            if (ack) begin
               sp_we    = 1'b1;
               sp_wdata = sp + 16'h0002;
               pc_d     = tmp_q;
               psw_d    = MEM_RSP.rdata;
               pcl_d    = 1'b1;
               done_d   = 1'b1;
               state_d  = tcs_pkg::TCS_ST_IDLE;
            end
         end
         tcs_pkg::TCS_ST_XFER: begin
            // To: pop current stack; from: read previous space
            MEM_REQ.req    = 1'b1;
            MEM_REQ.ispace = op_isp && !op_to;
            MEM_REQ.mode   = op_to ? cur_mode : prv_mode;
            MEM_REQ.addr   = op_to ? sp : xaddr_q;
            if (ack) begin
               tmp_d = MEM_RSP.rdata;
               if (op_to) begin
                  sp_we    = 1'b1;
                  sp_wdata = sp + 16'h0002;
               end
               state_d = tcs_pkg::TCS_ST_PUSH_X;
            end
         end
         tcs_pkg::TCS_ST_PUSH_X: begin
            MEM_REQ.req    = 1'b1;
            MEM_REQ.wr     = 1'b1;
            MEM_REQ.ispace = op_isp && op_to;
            MEM_REQ.mode   = op_to ? prv_mode : cur_mode;
            MEM_REQ.addr   = op_to ? xaddr_q : sp - 16'h0002;
            MEM_REQ.wdata  = tmp_q;
            if (ack) begin
               if (!op_to) begin
                  sp_we    = 1'b1;
                  sp_wdata = sp - 16'h0002;
               end
               done_d  = 1'b1;
               state_d = tcs_pkg::TCS_ST_IDLE;
            end
         end
         default: state_d = tcs_pkg::TCS_ST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         state_q <= tcs_pkg::TCS_ST_IDLE;
         psw_q   <= `TCS_PSW_RESET_VAL;
         pc_q    <= `TCS_PC_RESET_VAL;
         spc_q   <= `TCS_PC_RESET_VAL;
         vec_q   <= 16'h0000;
         tmp_q   <= 16'h0000;
         xaddr_q <= 16'h0000;
         op_q    <= tcs_pkg::TCS_OP_NONE;
         done_q  <= 1'b0;
         pcl_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         psw_q   <= psw_d;
         pc_q    <= pc_d;
         spc_q   <= spc_d;
         vec_q   <= vec_d;
         tmp_q   <= tmp_d;
         xaddr_q <= xaddr_d;
         op_q    <= op_d;
         done_q  <= done_d;
         pcl_q   <= pcl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign PC_OUT    = pc_q;
   assign PSW_OUT   = psw_q;
   assign SP_OUT    = sp;
   assign XFER_DATA = tmp_q;
   assign BUSY      = !idle;
   assign DONE      = done_q;
   assign PC_LOAD   = pcl_q;

endmodule : tcs_trap_context_switch
`default_nettype wire

/* dv/tcs_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Stack memory and maps keyed by mode, space and address; random ack delay
module tcs_mem_model (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire tcs_pkg::tcs_mem_req_t req,
   output tcs_pkg::tcs_mem_rsp_t      rsp
);
   logic [15:0] mem [0:524287];
   logic [18:0] key;
   logic [15:0] last_q;
   int          wait_q;
   int          seed;
   assign key = {req.mode, req.ispace, req.addr};
   assign rsp.ack = req.req && (wait_q == 0);
   // Outside an answered read the data lines show the inverse of the last word transferred, held until the next ack
   assign rsp.rdata = (rsp.ack && !req.wr) ? mem[key] : ~last_q;
   initial seed = 65069;
   always @(posedge clk) begin
      if (!rst_n) begin
         wait_q <= 0;
         last_q <= 16'h0000;
      end else if (rsp.ack) begin
         if (req.wr) mem[key] <= req.wdata;
         last_q <= req.wr ? req.wdata : rsp.rdata;
         wait_q <= $unsigned($random(seed)) % 3;
      end else if (req.req) begin
         wait_q <= wait_q - 1;
      end
   end
endmodule : tcs_mem_model
`default_nettype wire

/* dv/tcs_trap_context_switch_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module tcs_trap_context_switch_monitor (
   input wire logic                  REF_CLK,
   input wire logic                  RST_N,
   input wire tcs_pkg::tcs_cause_t   TRAP_CAUSE,
   input wire tcs_pkg::tcs_op_t      OP,
   input wire logic [15:0]           OP_ADDR,
   input wire logic                  OP_WORD,
   input wire logic                  OP_START,
   input wire logic                  CONST_FETCH,
   input wire logic [15:0]           CONST_ADDR,
   input wire tcs_pkg::tcs_mem_rsp_t MEM_RSP,
   input wire tcs_pkg::tcs_mem_req_t MEM_REQ,
   input wire logic [15:0]           PC_OUT,
   input wire logic [15:0]           PSW_OUT,
   input wire logic [15:0]           SP_OUT,
   input wire logic                  BUSY,
   input wire logic                  DONE,
   input wire logic                  PC_LOAD
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   logic idle_trap;
   logic move_op;
   assign move_op = OP == tcs_pkg::TCS_OP_MOVE_TO_PREV_ISPACE ||
                    OP == tcs_pkg::TCS_OP_MOVE_TO_PREV_DSPACE ||
                    OP == tcs_pkg::TCS_OP_MOVE_FROM_PREV_ISPACE ||
                    OP == tcs_pkg::TCS_OP_MOVE_FROM_PREV_DSPACE;
   assign idle_trap = !BUSY && (TRAP_CAUSE != tcs_pkg::TCS_CAUSE_NONE);
   AST_DONE_PULSE: assert property (DONE |=> !DONE)
      else $error("done longer than one cycle");
   AST_PC_LOAD_DONE: assert property (PC_LOAD |-> DONE)
      else $error("pc load outside done");
   AST_PC_CHANGE: assert property ($changed(PC_OUT) |-> PC_LOAD)
      else $error("pc changed without load");
   AST_PSW_CHANGE: assert property ($changed(PSW_OUT) |-> DONE)
      else $error("status word changed outside done");
   AST_REQ_HOLD: assert property (BUSY && MEM_REQ.req && !MEM_RSP.ack
      |=> MEM_REQ.req && $stable(MEM_REQ.addr) && $stable(MEM_REQ.wr))
      else $error("memory request dropped before ack");
   AST_CONST_FETCH: assert property (!BUSY && CONST_FETCH |-> MEM_REQ.req && MEM_REQ.ispace
      && MEM_REQ.addr == CONST_ADDR && MEM_REQ.mode == PSW_OUT[15:14])
      else $error("constant fetch not in current instruction space");
   AST_PUSH_FIRST: assert property (idle_trap |=> MEM_REQ.req && MEM_REQ.wr
      && MEM_REQ.wdata == $past(PSW_OUT) && MEM_REQ.addr == $past(SP_OUT) - 16'h0002)
      else $error("trap does not push status word first");
   AST_ODD_TRAP: assert property (!BUSY && TRAP_CAUSE == tcs_pkg::TCS_CAUSE_NONE && OP_START
      && move_op && OP_WORD && OP_ADDR[0] |=> MEM_REQ.req && MEM_REQ.wr)
      else $error("odd word move did not trap");
   AST_DONE_BOUND: assert property ($rose(BUSY) |-> ##[2:60] DONE)
      else $error("operation did not finish");
   COV_TRAP: cover property (idle_trap ##1 BUSY);
   COV_LOAD: cover property (DONE && PC_LOAD);
   COV_MOVE: cover property (DONE && !PC_LOAD);
endmodule : tcs_trap_context_switch_monitor
bind tcs_trap_context_switch tcs_trap_context_switch_monitor i_mon (.REF_CLK, .RST_N,
   .TRAP_CAUSE, .OP, .OP_ADDR, .OP_WORD, .OP_START, .CONST_FETCH, .CONST_ADDR, .MEM_RSP,
   .MEM_REQ, .PC_OUT, .PSW_OUT, .SP_OUT, .BUSY, .DONE, .PC_LOAD);
`default_nettype wire

/* dv/tcs_trap_context_switch_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcs_map.svh"
module tcs_trap_context_switch_tb_top;
   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] psw;
      logic [15:0] xd;
      logic        xm;
   } tcs_exp_t;
   logic                  REF_CLK = 0, RST_N = 0, OP_WORD = 0, OP_START = 0;
   logic                  CONST_FETCH = 0, GPR_WE = 0, BUSY, DONE, PC_LOAD;
   logic [2:0]            GPR_WADDR = 0, GPR_RADDR = 0;
   logic [15:0]           INTR_VECTOR = 16'h0040, OP_ADDR = 0, CUR_PC = 0, CONST_ADDR = 0;
   logic [15:0]           GPR_WDATA = 0, GPR_RDATA, PC_OUT, PSW_OUT, SP_OUT, XFER_DATA;
   tcs_pkg::tcs_cause_t   TRAP_CAUSE = tcs_pkg::TCS_CAUSE_NONE;
   tcs_pkg::tcs_op_t      OP = tcs_pkg::TCS_OP_NONE;
   tcs_pkg::tcs_mem_req_t MEM_REQ;
   tcs_pkg::tcs_mem_rsp_t MEM_RSP;
   tcs_exp_t              exp_q[$];
   tcs_exp_t              e;
   logic [15:0]           vpc [1:6], vps [1:6], v, rw, pc_e;
   int                    fail_count = 0, checks = 0, cycles = 0, seed = 65069;
   tcs_trap_context_switch i_dut (.REF_CLK, .RST_N, .TRAP_CAUSE, .INTR_VECTOR, .OP, .OP_ADDR,
      .OP_WORD, .OP_START, .CUR_PC, .CONST_FETCH, .CONST_ADDR, .GPR_WE, .GPR_WADDR,
      .GPR_WDATA, .GPR_RADDR, .MEM_RSP, .MEM_REQ, .GPR_RDATA, .PC_OUT, .PSW_OUT, .SP_OUT,
      .XFER_DATA, .BUSY, .DONE, .PC_LOAD);
   tcs_mem_model i_mem (.clk(REF_CLK), .rst_n(RST_N), .req(MEM_REQ), .rsp(MEM_RSP));
   initial forever #4 REF_CLK = ~REF_CLK;
   task automatic final_report;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end
   // Oldest expectation is matched against each completion
   always @(negedge REF_CLK) if (DONE === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h0000, 16'h0001, "unexpected done");
      else begin
         e = exp_q.pop_front();
         chk(PC_OUT, e.pc, "pc");
         chk(PSW_OUT, e.psw, "status word");
         if (e.xm) chk(XFER_DATA, e.xd, "moved word");
      end
   end
   task automatic go(input tcs_pkg::tcs_cause_t c, input tcs_pkg::tcs_op_t o,
                     input logic [15:0] a, input tcs_exp_t x);
      int n;
      n = 0;
      exp_q.push_back(x);
      @(posedge REF_CLK) #1;
      TRAP_CAUSE = c;
      OP = o;
      OP_ADDR = a;
      OP_WORD = 1'b1;
      OP_START = (o != tcs_pkg::TCS_OP_NONE);
      @(posedge REF_CLK) #1;
      TRAP_CAUSE = tcs_pkg::TCS_CAUSE_NONE;
      OP_START = 1'b0;
      while (n < 60) begin
         @(posedge REF_CLK) #1;
         n = (DONE === 1'b1) ? 99 : n + 1;
      end
      if (n != 99) chk(16'h0000, 16'h0001, "no done");
   endtask : go
   task automatic trap(input int i);
      CUR_PC = $random(seed) & 16'hFFFE;
      pc_e = CUR_PC;
      go(tcs_pkg::tcs_cause_t'(i[2:0]), tcs_pkg::TCS_OP_NONE, 16'h0000,
         '{vpc[i], vps[i], 16'h0000, 1'b0});
      chk(SP_OUT, 16'hFFFC, "stack after trap");
   endtask : trap
   task automatic ret(input tcs_pkg::tcs_op_t o, input logic [15:0] s);
      go(tcs_pkg::TCS_CAUSE_NONE, o, 16'h0000, '{pc_e, s, 16'h0000, 1'b0});
   endtask : ret
   initial begin
      for (int i = 1; i < 7; i++) begin
         case (i)
            1: v = `TCS_VEC_ODD_ADDR;
            2: v = `TCS_VEC_RESERVED;
            3: v = `TCS_VEC_EMU_TRAP;
            4: v = `TCS_VEC_TRAP;
            5: v = `TCS_VEC_IO_TRAP;
            default: v = INTR_VECTOR;
         endcase
         vpc[i] = $random(seed) & 16'hFFFE;
         vps[i] = i[0] ? 16'h08E0 : 16'h00E0;
         i_mem.mem[{3'h0, v}] = vpc[i];
         i_mem.mem[{3'h0, v + 16'h0002}] = vps[i];
      end
      repeat (16) @(posedge REF_CLK);
      #1 RST_N = 1'b1;
      CONST_FETCH = 1'b1;
      CONST_ADDR = 16'h0124;
      @(posedge REF_CLK) #1 CONST_FETCH = 1'b0;
      for (int i = 1; i < 7; i++) begin
         trap(i);
         ret(i[0] ? tcs_pkg::TCS_OP_RET_INT : tcs_pkg::TCS_OP_RET_TRP, 16'h0000);
      end
      CUR_PC = 16'h0400;
      pc_e = CUR_PC;
      go(tcs_pkg::TCS_CAUSE_NONE, tcs_pkg::TCS_OP_MOVE_FROM_PREV_DSPACE, 16'h0201,
         '{vpc[1], vps[1], 16'h0000, 1'b0});
      ret(tcs_pkg::TCS_OP_RET_INT, 16'h0000);
      $display("test traps and returns done");
      GPR_WE = 1'b1;
      GPR_WADDR = 3'h2;
      GPR_WDATA = 16'h1234;
      @(posedge REF_CLK) #1 GPR_WE = 1'b0;
      GPR_RADDR = 3'h2;
      trap(3);
      @(posedge REF_CLK) #1 chk(GPR_RDATA, 16'h0000, "alternate set");
      ret(tcs_pkg::TCS_OP_RET_TRP, 16'h0000);
      @(posedge REF_CLK) #1 chk(GPR_RDATA, 16'h1234, "first set");
      $display("test register sets done");
      trap(4);
      i_mem.mem[{3'h0, 16'hFFFE}] = 16'h3000;
      ret(tcs_pkg::TCS_OP_RET_INT, 16'h3000);
      rw = $random(seed);
      i_mem.mem[{3'h6, 16'h0200}] = rw;
      go(tcs_pkg::TCS_CAUSE_NONE, tcs_pkg::TCS_OP_MOVE_FROM_PREV_DSPACE, 16'h0200,
         '{pc_e, 16'h3000, rw, 1'b1});
      chk(SP_OUT, 16'hFFFE, "stack after move from");
      go(tcs_pkg::TCS_CAUSE_NONE, tcs_pkg::TCS_OP_MOVE_TO_PREV_ISPACE, 16'h0300,
         '{pc_e, 16'h3000, rw, 1'b1});
      chk(i_mem.mem[{3'h7, 16'h0300}], rw, "previous instruction space");
      chk(SP_OUT, 16'h0000, "stack after move to");
      $display("test cross-space moves done");
      final_report();
   end
endmodule : tcs_trap_context_switch_tb_top
`default_nettype wire
